// [common/usb_ep_defs.svh]
`ifndef USB_EP_DEFS_SVH
`define USB_EP_DEFS_SVH

// register indices; byte address is four times the index
`define IDX_CTRL_IN_CONFIG 16'hFF80
`define IDX_CTRL_IN_COUNT 16'hFF81
`define IDX_CTRL_OUT_CONFIG 16'hFF82
`define IDX_CTRL_OUT_COUNT 16'hFF83
`define IDX_IN_EDB1 16'hFF48
`define EDB_STRIDE 16'h0008
`define OFS_IN_Y_COUNT 16'h0006
`define OFS_IN_BUF_SIZE 16'h0007
`define IDX_IRQ_STATUS 16'hFFE0
`define IDX_IRQ_MASK 16'hFFE1
`define AXI_ADDR_W 18

// fixed endpoint 0 buffer addresses
`define EP0_OUT_BUF 16'hFEF0
`define EP0_IN_BUF 16'hFEF8

// field positions
`define CFG_IE_BIT 2
`define CFG_STALL_BIT 3
`define CFG_TOGGLE_BIT 5
`define CFG_BUFFER_MANAGER_ENABLE_BIT 7
`define CNT_NAK_BIT 7

// limits and reset values
`define EP0_MAX_COUNT 4'h8
`define EP_MAX_SIZE 7'h40
`define CFG_RESET 8'h00
`define CNT_RESET 8'h80
`define SIZE_RESET 7'h40

// interrupt status bits
`define IRQ_EP0_IN 0
`define IRQ_EP0_OUT 1
`define IRQ_SETUP 2
`define IRQ_EPN_IN 3
`define IRQ_W 6

`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

// [common/usb_ep_pkg.sv]
package usb_ep_pkg;

   typedef enum logic [1:0] {
      PID_OUT,
      PID_IN,
      PID_SETUP
   } token_t;

   typedef enum logic [2:0] {
      HS_NONE,
      HS_ACK,
      HS_NAK,
      HS_STALL,
      HS_DATA
   } handshake_t;

endpackage : usb_ep_pkg

// [common/reg_port_if.sv]
`timescale 1ns/10ps
`include "usb_ep_defs.svh"

interface reg_port_if;
   logic wr;
   logic [`AXI_ADDR_W-1:0] waddr;
   logic [7:0] wdata;
   logic wr_hit;
   logic [`AXI_ADDR_W-1:0] raddr;
   logic [7:0] rdata;
   logic rd_hit;

   modport bus (output wr, waddr, wdata, raddr, input wr_hit, rdata, rd_hit);
   modport regs (input wr, waddr, wdata, raddr, output wr_hit, rdata, rd_hit);
endinterface : reg_port_if

// [design/usb_axil_slave.sv]
`timescale 1ns/10ps
`include "usb_ep_defs.svh"

module usb_axil_slave (
   input wire logic clk,
   input wire logic rst,
   input wire logic [`AXI_ADDR_W-1:0] awaddr,
   input wire logic awvalid,
   output logic awready,
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   input wire logic wvalid,
   output logic wready,
   output logic [1:0] bresp,
   output logic bvalid,
   input wire logic bready,
   input wire logic [`AXI_ADDR_W-1:0] araddr,
   input wire logic arvalid,
   output logic arready,
   output logic [31:0] rdata,
   output logic [1:0] rresp,
   output logic rvalid,
   input wire logic rready,
   reg_port_if.bus rp
);

   logic lane0;
   logic rd_pend;

   ////////////////////////////////////////////////////////////////////////
   // write: aw and w in either order
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         awready <= 1'b1;
         wready <= 1'b1;
         bvalid <= 1'b0;
         bresp <= `RESP_OKAY;
         rp.wr <= 1'b0;
         rp.waddr <= '0;
         rp.wdata <= 8'h00;
         lane0 <= 1'b0;
      end else begin
         rp.wr <= 1'b0;
         if (awvalid && awready) begin
            awready <= 1'b0;
            rp.waddr <= awaddr;
         end
         if (wvalid && wready) begin
            wready <= 1'b0;
            rp.wdata <= wdata[7:0];
            lane0 <= wstrb[0];
         end
         if (!awready && !wready && !bvalid) begin
            // bytes above lane 0 hold no register bits
            rp.wr <= lane0;
            bvalid <= 1'b1;
            bresp <= rp.wr_hit ? `RESP_OKAY : `RESP_SLVERR;
         end
         if (bvalid && bready) begin
            bvalid <= 1'b0;
            awready <= 1'b1;
            wready <= 1'b1;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // read: data one cycle after address
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         arready <= 1'b1;
         rvalid <= 1'b0;
         rd_pend <= 1'b0;
         rdata <= 32'h0000_0000;
         rresp <= `RESP_OKAY;
         rp.raddr <= '0;
      end else begin
         if (arvalid && arready) begin
            arready <= 1'b0;
            rp.raddr <= araddr;
            rd_pend <= 1'b1;
         end
         if (rd_pend) begin
            rd_pend <= 1'b0;
            rvalid <= 1'b1;
            rdata <= {24'h000000, rp.rdata};
            rresp <= rp.rd_hit ? `RESP_OKAY : `RESP_SLVERR;
         end
         if (rvalid && rready) begin
            rvalid <= 1'b0;
            arready <= 1'b1;
         end
      end
   end

endmodule : usb_axil_slave

// [design/ep0_dir_ctrl.sv]
`timescale 1ns/10ps
`include "usb_ep_defs.svh"

module ep0_dir_ctrl #(
   parameter bit IS_IN = 1'b1
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic cfg_we,
   input wire logic cnt_we,
   input wire logic [7:0] wdata,
   input wire logic setup_evt,
   input wire logic done_evt,
   input wire logic [3:0] done_count,
   output logic [7:0] cfg,
   output logic [7:0] cnt
);

   logic buffer_manager_enable;
   logic stall;
   logic ie;
   logic toggle;
   logic nak;
   logic [3:0] count;

   function automatic logic [3:0] sat8(input logic [3:0] c);
      sat8 = (c > `EP0_MAX_COUNT) ? `EP0_MAX_COUNT : c;
   endfunction : sat8

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         buffer_manager_enable <= 1'b0;
         ie <= 1'b0;
         stall <= 1'b0;
      end else begin
         if (cfg_we) begin
            buffer_manager_enable <= wdata[`CFG_BUFFER_MANAGER_ENABLE_BIT];
            ie <= wdata[`CFG_IE_BIT];
            stall <= wdata[`CFG_STALL_BIT];
         end
         // setup beats a stall write
         if (setup_evt) begin
            stall <= 1'b0;
         end
      end
   end

   // toggle is hardware-owned; a setup starts the data stage on DATA1
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         toggle <= 1'b0;
      end else if (setup_evt) begin
         toggle <= 1'b1;
      end else if (done_evt) begin
         toggle <= ~toggle;
      end
   end

   // completion beats a firmware clear
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         nak <= 1'b1;
      end else if (done_evt) begin
         nak <= 1'b1;
      end else if (cnt_we) begin
         nak <= wdata[`CNT_NAK_BIT];
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         count <= 4'h0;
      end else if (IS_IN && cnt_we) begin
         count <= sat8(wdata[3:0]);
      end else if (!IS_IN && done_evt) begin
         count <= sat8(done_count);
      end
   end

   assign cfg = {buffer_manager_enable, 1'b0, toggle, 1'b0, stall, ie, 2'b00};
   assign cnt = {nak, 3'b000, count};

endmodule : ep0_dir_ctrl

// [design/usb_endpoint_descriptor_ctrl.sv]
// The implementer's own choice: the AXI4-Lite register port.
`timescale 1ns/10ps
`include "usb_ep_defs.svh"

module usb_endpoint_descriptor_ctrl (
   input wire logic clk,
   input wire logic rst,
   input wire logic [`AXI_ADDR_W-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [`AXI_ADDR_W-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic tok_valid,
   input wire usb_ep_pkg::token_t tok_pid,
   input wire logic [1:0] tok_ep,
   input wire logic [3:0] rx_count,
   input wire logic in_ack,
   output logic hs_valid,
   output usb_ep_pkg::handshake_t hs_code,
   output logic [6:0] tx_count,
   output logic tx_toggle,
   output logic [15:0] buf_addr,
   output logic bm_access,
   output logic irq
);

   reg_port_if rp ();

   logic [7:0] in_cfg;
   logic [7:0] in_cnt;
   logic [7:0] out_cfg;
   logic [7:0] out_cnt;
   logic [7:0] y_count [1:3];
   logic [6:0] buf_size [1:3];
   logic [2:0] epn_toggle;
   logic [`IRQ_W-1:0] irq_status;
   logic [`IRQ_W-1:0] irq_mask;
   logic in_pend;
   logic [1:0] in_pend_ep;
   logic setup_evt;
   logic out0_done;
   logic in0_done;
   logic [3:1] inn_done;
   logic [15:0] widx;
   logic [15:0] ridx;
   logic [`IRQ_W-1:0] next_irq_status;

   ////////////////////////////////////////////////////////////////////////
   usb_axil_slave u_bus (
      .clk(clk),
      .rst(rst),
      .awaddr(s_axi_awaddr),
      .awvalid(s_axi_awvalid),
      .awready(s_axi_awready),
      .wdata(s_axi_wdata),
      .wstrb(s_axi_wstrb),
      .wvalid(s_axi_wvalid),
      .wready(s_axi_wready),
      .bresp(s_axi_bresp),
      .bvalid(s_axi_bvalid),
      .bready(s_axi_bready),
      .araddr(s_axi_araddr),
      .arvalid(s_axi_arvalid),
      .arready(s_axi_arready),
      .rdata(s_axi_rdata),
      .rresp(s_axi_rresp),
      .rvalid(s_axi_rvalid),
      .rready(s_axi_rready),
      .rp(rp.bus)
   );

   assign widx = rp.waddr[`AXI_ADDR_W-1:2];
   assign ridx = rp.raddr[`AXI_ADDR_W-1:2];

   function automatic logic epn_hit(input logic [15:0] idx);
      epn_hit = 1'b0;
      for (int n = 1; n <= 3; n++) begin
         if (idx == `IDX_IN_EDB1 + 16'(n - 1) * `EDB_STRIDE + `OFS_IN_Y_COUNT ||
             idx == `IDX_IN_EDB1 + 16'(n - 1) * `EDB_STRIDE + `OFS_IN_BUF_SIZE) begin
            epn_hit = 1'b1;
         end
      end
   endfunction : epn_hit

   function automatic logic ep0_hit(input logic [15:0] idx);
      ep0_hit = idx >= `IDX_CTRL_IN_CONFIG && idx <= `IDX_CTRL_OUT_COUNT;
   endfunction : ep0_hit

   assign rp.wr_hit = ep0_hit(widx) || epn_hit(widx) ||
                      widx == `IDX_IRQ_STATUS || widx == `IDX_IRQ_MASK;

   ////////////////////////////////////////////////////////////////////////
   // endpoint 0, one instance per direction
   ep0_dir_ctrl #(.IS_IN(1'b1)) u_ep0_in (
      .clk(clk),
      .rst(rst),
      .cfg_we(rp.wr && widx == `IDX_CTRL_IN_CONFIG),
      .cnt_we(rp.wr && widx == `IDX_CTRL_IN_COUNT),
      .wdata(rp.wdata),
      .setup_evt(setup_evt),
      .done_evt(in0_done),
      .done_count(4'h0),
      .cfg(in_cfg),
      .cnt(in_cnt)
   );

   ep0_dir_ctrl #(.IS_IN(1'b0)) u_ep0_out (
      .clk(clk),
      .rst(rst),
      .cfg_we(rp.wr && widx == `IDX_CTRL_OUT_CONFIG),
      .cnt_we(rp.wr && widx == `IDX_CTRL_OUT_COUNT),
      .wdata(rp.wdata),
      .setup_evt(setup_evt),
      .done_evt(out0_done),
      .done_count(rx_count),
      .cfg(out_cfg),
      .cnt(out_cnt)
   );

   ////////////////////////////////////////////////////////////////////////
   // input endpoints 1..3: Y count and shared X/Y size
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         for (int n = 1; n <= 3; n++) begin
            y_count[n] <= `CNT_RESET;
            buf_size[n] <= `SIZE_RESET;
         end
      end else begin
         for (int n = 1; n <= 3; n++) begin
            if (rp.wr && widx == `IDX_IN_EDB1 + 16'(n - 1) * `EDB_STRIDE
                + `OFS_IN_Y_COUNT) begin
               y_count[n] <= rp.wdata;
            end
            if (rp.wr && widx == `IDX_IN_EDB1 + 16'(n - 1) * `EDB_STRIDE
                + `OFS_IN_BUF_SIZE) begin
               buf_size[n] <= rp.wdata[6:0];
            end
            // host took the packet: buffer empty again, beats a firmware clear
            if (inn_done[n]) begin
               y_count[n][`CNT_NAK_BIT] <= 1'b1;
            end
         end
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         epn_toggle <= 3'h0;
      end else begin
         for (int n = 1; n <= 3; n++) begin
            if (inn_done[n]) begin
               epn_toggle[n-1] <= ~epn_toggle[n-1];
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // register read mux
   always_comb begin
      rp.rdata = 8'h00;
      rp.rd_hit = 1'b1;
      if (ridx == `IDX_CTRL_IN_CONFIG) begin
         rp.rdata = in_cfg;
      end else if (ridx == `IDX_CTRL_IN_COUNT) begin
         rp.rdata = in_cnt;
      end else if (ridx == `IDX_CTRL_OUT_CONFIG) begin
         rp.rdata = out_cfg;
      end else if (ridx == `IDX_CTRL_OUT_COUNT) begin
         rp.rdata = out_cnt;
      end else if (ridx == `IDX_IRQ_STATUS) begin
         rp.rdata = {2'b00, irq_status};
      end else if (ridx == `IDX_IRQ_MASK) begin
         rp.rdata = {2'b00, irq_mask};
      end else begin
         rp.rd_hit = epn_hit(ridx);
         for (int n = 1; n <= 3; n++) begin
            if (ridx == `IDX_IN_EDB1 + 16'(n - 1) * `EDB_STRIDE + `OFS_IN_Y_COUNT) begin
               rp.rdata = y_count[n];
            end
            if (ridx == `IDX_IN_EDB1 + 16'(n - 1) * `EDB_STRIDE + `OFS_IN_BUF_SIZE) begin
               rp.rdata = {1'b0, buf_size[n]};
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // transaction events, all single-cycle
   assign setup_evt = tok_valid && tok_pid == usb_ep_pkg::PID_SETUP && tok_ep == 2'd0;
   assign in0_done = in_ack && in_pend && in_pend_ep == 2'd0;
   assign out0_done = tok_valid && tok_pid == usb_ep_pkg::PID_OUT && tok_ep == 2'd0 &&
                      !out_cfg[`CFG_STALL_BIT] && !irq_status[`IRQ_SETUP] &&
                      out_cfg[`CFG_BUFFER_MANAGER_ENABLE_BIT] && !out_cnt[`CNT_NAK_BIT];

   always_comb begin
      for (int n = 1; n <= 3; n++) begin
         inn_done[n] = in_ack && in_pend && in_pend_ep == 2'(n);
      end
   end

   // data answer waits for host ack
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         in_pend <= 1'b0;
         in_pend_ep <= 2'd0;
      end else if (tok_valid) begin
         in_pend <= tok_pid == usb_ep_pkg::PID_IN && next_is_data();
         in_pend_ep <= tok_ep;
      end else if (in_ack) begin
         in_pend <= 1'b0;
      end
   end

   function automatic logic next_is_data();
      if (tok_ep == 2'd0) begin
         next_is_data = !in_cfg[`CFG_STALL_BIT] && !irq_status[`IRQ_SETUP] &&
                        in_cfg[`CFG_BUFFER_MANAGER_ENABLE_BIT] && !in_cnt[`CNT_NAK_BIT];
      end else begin
         next_is_data = !y_count[tok_ep][`CNT_NAK_BIT];
      end
   endfunction : next_is_data

   ////////////////////////////////////////////////////////////////////////
   // handshake; stall beats setup NAK
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         hs_valid <= 1'b0;
         hs_code <= usb_ep_pkg::HS_NONE;
         tx_count <= 7'h00;
         tx_toggle <= 1'b0;
         buf_addr <= 16'h0000;
         bm_access <= 1'b0;
      end else begin
         hs_valid <= tok_valid;
         bm_access <= 1'b0;
         if (tok_valid) begin
            hs_code <= usb_ep_pkg::HS_NONE;
            tx_count <= 7'h00;
            tx_toggle <= 1'b0;
            buf_addr <= 16'h0000;
            unique case (tok_pid)
               usb_ep_pkg::PID_SETUP: begin
                  if (tok_ep == 2'd0) begin
                     hs_code <= usb_ep_pkg::HS_ACK;
                  end
               end
               usb_ep_pkg::PID_IN: begin
                  if (tok_ep == 2'd0) begin
                     buf_addr <= `EP0_IN_BUF;
                     tx_toggle <= in_cfg[`CFG_TOGGLE_BIT];
                     if (in_cfg[`CFG_STALL_BIT]) begin
                        hs_code <= usb_ep_pkg::HS_STALL;
                     end else if (irq_status[`IRQ_SETUP]) begin
                        hs_code <= usb_ep_pkg::HS_NAK;
                     end else if (!in_cfg[`CFG_BUFFER_MANAGER_ENABLE_BIT]) begin
                        hs_code <= usb_ep_pkg::HS_NAK;
                     end else if (in_cnt[`CNT_NAK_BIT]) begin
                        hs_code <= usb_ep_pkg::HS_NAK;
                     end else begin
                        hs_code <= usb_ep_pkg::HS_DATA;
                        tx_count <= {3'b000, in_cnt[3:0]};
                        bm_access <= 1'b1;
                     end
                  end else begin
                     tx_toggle <= epn_toggle[tok_ep - 2'd1];
                     if (y_count[tok_ep][`CNT_NAK_BIT]) begin
                        hs_code <= usb_ep_pkg::HS_NAK;
                     end else begin
                        hs_code <= usb_ep_pkg::HS_DATA;
                        // clamp to buffer size
                        tx_count <= (y_count[tok_ep][6:0] > buf_size[tok_ep]) ?
                                    buf_size[tok_ep] : y_count[tok_ep][6:0];
                        bm_access <= 1'b1;
                     end
                  end
               end
               usb_ep_pkg::PID_OUT: begin
                  if (tok_ep == 2'd0) begin
                     buf_addr <= `EP0_OUT_BUF;
                     tx_toggle <= out_cfg[`CFG_TOGGLE_BIT];
                     if (out_cfg[`CFG_STALL_BIT]) begin
                        hs_code <= usb_ep_pkg::HS_STALL;
                     end else if (irq_status[`IRQ_SETUP]) begin
                        hs_code <= usb_ep_pkg::HS_NAK;
                     end else if (!out_cfg[`CFG_BUFFER_MANAGER_ENABLE_BIT]) begin
                        hs_code <= usb_ep_pkg::HS_NAK;
                     end else if (out_cnt[`CNT_NAK_BIT]) begin
                        hs_code <= usb_ep_pkg::HS_NAK;
                     end else begin
                        hs_code <= usb_ep_pkg::HS_ACK;
                        bm_access <= 1'b1;
                     end
                  end
               end
               default: begin
                  hs_code <= usb_ep_pkg::HS_NONE;
               end
            endcase
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // w1c status; set beats clear
   always_comb begin
      next_irq_status = irq_status;
      if (rp.wr && widx == `IDX_IRQ_STATUS) begin
         next_irq_status = irq_status & ~rp.wdata[`IRQ_W-1:0];
      end
      if (in0_done && in_cfg[`CFG_IE_BIT]) begin
         next_irq_status[`IRQ_EP0_IN] = 1'b1;
      end
      if (out0_done && out_cfg[`CFG_IE_BIT]) begin
         next_irq_status[`IRQ_EP0_OUT] = 1'b1;
      end
      if (setup_evt) begin
         next_irq_status[`IRQ_SETUP] = 1'b1;
      end
      for (int n = 1; n <= 3; n++) begin
         if (inn_done[n]) begin
            next_irq_status[`IRQ_EPN_IN + n - 1] = 1'b1;
         end
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         irq_status <= '0;
      end else begin
         irq_status <= next_irq_status;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         irq_mask <= '0;
      end else if (rp.wr && widx == `IDX_IRQ_MASK) begin
         irq_mask <= rp.wdata[`IRQ_W-1:0];
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         irq <= 1'b0;
      end else begin
         irq <= |(next_irq_status & irq_mask);
      end
   end

endmodule : usb_endpoint_descriptor_ctrl

// [testbench/usb_host_model.sv]
`timescale 1ns/10ps
module usb_host_model (
   input wire logic clk,
   output logic tok_valid,
   output usb_ep_pkg::token_t tok_pid,
   output logic [1:0] tok_ep,
   output logic [3:0] rx_count,
   output logic in_ack,
   input wire logic hs_valid,
   input wire usb_ep_pkg::handshake_t hs_code
);
   initial begin
      tok_valid = 1'b0;
      tok_pid = usb_ep_pkg::PID_OUT;
      tok_ep = 2'h0;
      rx_count = 4'h0;
      in_ack = 1'b0;
   end
   // no answer reads as code 7
   task automatic xfer(input usb_ep_pkg::token_t p, input logic [1:0] e,
         input logic [3:0] c, output usb_ep_pkg::handshake_t h);
      tok_valid <= 1'b1;
      tok_pid <= p;
      tok_ep <= e;
      rx_count <= c;
      @(posedge clk);
      tok_valid <= 1'b0;
      rx_count <= ~c;
      #1;
      h = hs_valid ? hs_code : usb_ep_pkg::handshake_t'(3'h7);
      if (h == usb_ep_pkg::HS_DATA) begin
         @(posedge clk);
         in_ack <= 1'b1;
         @(posedge clk);
         in_ack <= 1'b0;
      end
      @(posedge clk);
   endtask : xfer
endmodule : usb_host_model

// [testbench/usb_endpoint_descriptor_ctrl_asserts.sv]
`timescale 1ns/10ps
`include "usb_ep_defs.svh"
module usb_endpoint_descriptor_ctrl_asserts (
   input wire logic clk,
   input wire logic rst,
   input wire logic tok_valid,
   input wire usb_ep_pkg::token_t tok_pid,
   input wire logic [1:0] tok_ep,
   input wire logic hs_valid,
   input wire usb_ep_pkg::handshake_t hs_code,
   input wire logic [6:0] tx_count,
   input wire logic [15:0] buf_addr,
   input wire logic bm_access,
   input wire logic s_axi_rvalid,
   input wire logic [31:0] s_axi_rdata
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);
   logic tin, ep0, dat, nak;
   assign tin = tok_valid && tok_pid == usb_ep_pkg::PID_IN;
   assign ep0 = tok_ep == 2'h0;
   assign dat = hs_code == usb_ep_pkg::HS_DATA;
   assign nak = hs_code == usb_ep_pkg::HS_NAK;
   ////////////////////////////////////////
   a_hs_answer: assert property (tok_valid |=> hs_valid)
      else $error("no handshake");
   a_hs_cause: assert property (hs_valid |-> $past(tok_valid))
      else $error("stray handshake");
   a_ep0_buf: assert property (tin && ep0 ##1 dat |-> buf_addr == `EP0_IN_BUF)
      else $error("ep0 buffer");
   a_ep0_len: assert property (tin && ep0 ##1 dat |-> tx_count <= 7'h08)
      else $error("ep0 count");
   a_epn_len: assert property (tin && !ep0 ##1 dat |-> tx_count <= 7'h40)
      else $error("epn count");
   a_epn_refused: assert property (tok_valid && !tin && !ep0 |=> hs_code == 3'h0)
      else $error("refused token answered");
   a_nak_no_bm: assert property (hs_valid && nak |-> !bm_access)
      else $error("bm on nak");
   a_bm_with_hs: assert property (bm_access |-> hs_valid && !nak)
      else $error("bm without answer");
   a_rdata_high: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
      else $error("rdata high set");
   c_ep0_data: cover property (tin && ep0 ##1 dat);
   c_nak: cover property (hs_valid && nak);
   c_stall: cover property (hs_valid && hs_code == usb_ep_pkg::HS_STALL);
endmodule : usb_endpoint_descriptor_ctrl_asserts
bind usb_endpoint_descriptor_ctrl usb_endpoint_descriptor_ctrl_asserts
   u_usb_endpoint_descriptor_ctrl_asserts (.*);

// [testbench/usb_endpoint_descriptor_ctrl_tb.sv]
`timescale 1ns/10ps
`include "usb_ep_defs.svh"
module usb_endpoint_descriptor_ctrl_tb;
   logic clk, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic tok_valid, in_ack, hs_valid, tx_toggle, bm_access, irq;
   logic rst = 1'b1, s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_arvalid = 1'b0;
   logic s_axi_bready = 1'b1, s_axi_rready = 1'b1;
   logic [3:0] s_axi_wstrb = 4'hF, rx_count;
   logic [`AXI_ADDR_W-1:0] s_axi_awaddr = '0, s_axi_araddr = '0;
   logic [31:0] s_axi_wdata = '0, s_axi_rdata, rv;
   logic [1:0] s_axi_bresp, s_axi_rresp, tok_ep, rs;
   logic [6:0] tx_count;
   logic [15:0] buf_addr;
   usb_ep_pkg::token_t tok_pid;
   usb_ep_pkg::handshake_t hs_code, hs;
   int error_cnt = 0;
   int compares = 0;
   usb_endpoint_descriptor_ctrl u_usb_endpoint_descriptor_ctrl (.*);
   usb_host_model u_usb_host_model (.*);
   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end
   ////////////////////////////////////////
   task automatic tally_and_finish();
      $display("compares %0d mismatches %0d", compares, error_cnt);
      if (error_cnt == 0 && compares > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask : tally_and_finish
   task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
      compares++;
      if (s !== e) begin
         error_cnt++;
         $display("[FAIL] %s exp %h seen %h", n, e, s);
      end
   endtask : chk
   // pre-edge value
   task automatic hold(ref logic s);
      int n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (s !== 1'b1 && n < 40);
      if (s !== 1'b1) begin
         error_cnt++;
         $display("[FAIL] bus wait exp 1 seen timeout");
         tally_and_finish();
      end
   endtask : hold
   task automatic wr(input logic [15:0] i, input logic [7:0] d);
      s_axi_awaddr <= {i, 2'b00};
      s_axi_wdata <= {24'h0, d};
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      hold(s_axi_awready);
      s_axi_awvalid <= 1'b0;
      s_axi_wvalid <= 1'b0;
      hold(s_axi_bvalid);
      chk("bresp", {30'h0, s_axi_bresp}, {30'h0, `RESP_OKAY});
   endtask : wr
   task automatic rd(input logic [15:0] i);
      s_axi_araddr <= {i, 2'b00};
      s_axi_arvalid <= 1'b1;
      hold(s_axi_arready);
      s_axi_arvalid <= 1'b0;
      hold(s_axi_rvalid);
      rv = s_axi_rdata;
      rs = s_axi_rresp;
   endtask : rd
   task automatic rdc(input logic [15:0] i, input logic [7:0] e);
      rd(i);
      chk($sformatf("reg %h", i), rv, {24'h0, e});
   endtask : rdc
   task automatic tx(input usb_ep_pkg::token_t p, input logic [1:0] e, input logic [3:0] c,
         input usb_ep_pkg::handshake_t x);
      u_usb_host_model.xfer(p, e, c, hs);
      chk("handshake", {29'h0, hs}, {29'h0, x});
   endtask : tx
   ////////////////////////////////////////
   task automatic t_reset();
      logic [15:0] ix [6];
      logic [7:0] ev [6];
      ix = '{`IDX_CTRL_IN_CONFIG, `IDX_CTRL_IN_COUNT, `IDX_CTRL_OUT_CONFIG,
         `IDX_CTRL_OUT_COUNT, `IDX_IN_EDB1 + `OFS_IN_Y_COUNT, `IDX_IN_EDB1 + `OFS_IN_BUF_SIZE};
      ev = '{8'h00, 8'h80, 8'h00, 8'h80, 8'h80, 8'h40};
      foreach (ix[k]) begin
         rdc(ix[k], ev[k]);
      end
      rd(16'h0000);
      chk("unmapped resp", {30'h0, rs}, {30'h0, `RESP_SLVERR});
      $display("t_reset done");
   endtask : t_reset
   task automatic t_in_ep0();
      wr(`IDX_IRQ_MASK, 8'h01);
      wr(`IDX_CTRL_IN_CONFIG, 8'h84);
      wr(`IDX_CTRL_IN_COUNT, 8'h0F);
      rdc(`IDX_CTRL_IN_COUNT, 8'h08);
      tx(usb_ep_pkg::PID_IN, 2'h0, 4'h0, usb_ep_pkg::HS_DATA);
      chk("in buffer", {16'h0, buf_addr}, {16'h0, `EP0_IN_BUF});
      chk("in length", {25'h0, tx_count}, 32'h8);
      chk("in toggle", {31'h0, tx_toggle}, 32'h0);
      rdc(`IDX_CTRL_IN_COUNT, 8'h88);
      rdc(`IDX_CTRL_IN_CONFIG, 8'hA4);
      chk("irq set", {31'h0, irq}, 32'h1);
      rdc(`IDX_IRQ_STATUS, 8'h01);
      wr(`IDX_IRQ_STATUS, 8'h01);
      rdc(`IDX_IRQ_STATUS, 8'h00);
      chk("irq clear", {31'h0, irq}, 32'h0);
      tx(usb_ep_pkg::PID_IN, 2'h0, 4'h0, usb_ep_pkg::HS_NAK);
      $display("t_in_ep0 done");
   endtask : t_in_ep0
   task automatic t_stall();
      wr(`IDX_CTRL_IN_COUNT, 8'h03);
      wr(`IDX_CTRL_IN_CONFIG, 8'h8C);
      tx(usb_ep_pkg::PID_IN, 2'h0, 4'h0, usb_ep_pkg::HS_STALL);
      tx(usb_ep_pkg::PID_SETUP, 2'h0, 4'h8, usb_ep_pkg::HS_ACK);
      rdc(`IDX_CTRL_IN_CONFIG, 8'hA4);
      rdc(`IDX_IRQ_STATUS, 8'h04);
      tx(usb_ep_pkg::PID_IN, 2'h0, 4'h0, usb_ep_pkg::HS_NAK);
      wr(`IDX_IRQ_STATUS, 8'h04);
      tx(usb_ep_pkg::PID_IN, 2'h0, 4'h0, usb_ep_pkg::HS_DATA);
      chk("setup toggle", {31'h0, tx_toggle}, 32'h1);
      chk("short length", {25'h0, tx_count}, 32'h3);
      wr(`IDX_IRQ_STATUS, 8'h01);
      $display("t_stall done");
   endtask : t_stall
   task automatic t_buffer_manager_enable();
      wr(`IDX_CTRL_IN_CONFIG, 8'h00);
      wr(`IDX_CTRL_IN_COUNT, 8'h02);
      tx(usb_ep_pkg::PID_IN, 2'h0, 4'h0, usb_ep_pkg::HS_NAK);
      rdc(`IDX_CTRL_IN_COUNT, 8'h02);
      $display("t_buffer_manager_enable done");
   endtask : t_buffer_manager_enable
   task automatic t_out();
      wr(`IDX_CTRL_OUT_CONFIG, 8'h80);
      wr(`IDX_CTRL_OUT_COUNT, 8'h00);
      tx(usb_ep_pkg::PID_OUT, 2'h0, 4'h5, usb_ep_pkg::HS_ACK);
      chk("out buffer", {16'h0, buf_addr}, {16'h0, `EP0_OUT_BUF});
      rdc(`IDX_CTRL_OUT_COUNT, 8'h85);
      tx(usb_ep_pkg::PID_OUT, 2'h0, 4'h6, usb_ep_pkg::HS_NAK);
      rdc(`IDX_IRQ_STATUS, 8'h00);
      wr(`IDX_CTRL_OUT_COUNT, 8'h03);
      rdc(`IDX_CTRL_OUT_COUNT, 8'h05);
      $display("t_out done");
   endtask : t_out
   task automatic t_epn();
      wr(`IDX_IN_EDB1 + `OFS_IN_Y_COUNT, 8'h40);
      wr(`IDX_IN_EDB1 + `OFS_IN_BUF_SIZE, 8'h90);
      rdc(`IDX_IN_EDB1 + `OFS_IN_BUF_SIZE, 8'h10);
      tx(usb_ep_pkg::PID_IN, 2'h1, 4'h0, usb_ep_pkg::HS_DATA);
      chk("epn length", {25'h0, tx_count}, 32'h10);
      tx(usb_ep_pkg::PID_OUT, 2'h2, 4'h4, usb_ep_pkg::HS_NONE);
      tx(usb_ep_pkg::PID_SETUP, 2'h3, 4'h8, usb_ep_pkg::HS_NONE);
      $display("t_epn done");
   endtask : t_epn
   initial begin
      repeat (6) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      t_reset();
      t_in_ep0();
      t_stall();
      t_buffer_manager_enable();
      t_out();
      t_epn();
      tally_and_finish();
   end
endmodule : usb_endpoint_descriptor_ctrl_tb
